// file: crp_checker.sv
/*
  crp_checker: assertions on the pins between core and system logic.
  Assumes one clk domain and a synchronous active-low rst_n.
*/
`timescale 1ns/100ps
module crp_checker
  import crp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset_in_n,
  input wire logic power_on_reset_in_n,
  input wire logic soft_reset_mask_req,
  input wire logic [7:0] hw_int,
  input wire logic nmi,
  input wire logic exception_level_out,
  input wire logic error_level_out,
  input wire logic debug_mode_out,
  input wire logic sleep_out,
  input wire logic core_reset_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // reset intake and pulse
  pwr_reset_a: assert property (!power_on_reset_in_n |-> ##[1:3] core_reset_active)
    else $error("power-on reset not taken");
  soft_reset_a: assert property (!soft_reset_in_n && !(soft_reset_mask_req && debug_mode_out)
    |-> ##[1:3] core_reset_active) else $error("soft reset not taken");
  pulse_min_a: assert property ($fell(core_reset_active) |-> $past(core_reset_active, 6))
    else $error("reset pulse too short");
  pulse_len_a: assert property ($rose(power_on_reset_in_n) && soft_reset_in_n
    |-> core_reset_active [*6] ##[1:4] !core_reset_active) else $error("reset pulse length");
  err_lvl_rst_a: assert property (core_reset_active [*3] |-> error_level_out)
    else $error("error level not set in reset");

  // ==========================================================
  // levels and sleep
  one_level_a: assert property ($onehot0({$rose(exception_level_out),
    $rose(error_level_out), $rose(debug_mode_out)})) else $error("two level bits rose");
  sleep_rst_a: assert property (core_reset_active [*2] |-> !sleep_out)
    else $error("sleep during reset");
  wake_a: assert property (sleep_out && (!power_on_reset_in_n || nmi || |hw_int)
    |-> ##[1:5] !sleep_out) else $error("no wake from sleep");

  // main scenarios
  pulse_c: cover property ($fell(core_reset_active));
  wake_c: cover property ($fell(sleep_out));
  debug_c: cover property ($rose(debug_mode_out));
endmodule // crp_checker

// file: crp_core.sv
/*
  crp_core: reset intake, level bits and sleep indication of the core.
  Assumes the system logic drives the reset, interrupt and mask pins
  asynchronously; the execute side gives one-cycle exception commands.
*/
`timescale 1ns/100ps
module crp_core
  import crp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  crp_if.core link,
  input wire logic exc_req,
  input wire logic err_req,
  input wire logic dbg_req,
  input wire logic eret_req,
  input wire logic deret_req,
  input wire logic wait_req,
  input wire logic soft_flag_clear,
  output logic [31:0] status_reg,
  output logic [31:0] debug_reg,
  output logic core_run
);
  logic [11:0] syn;
  logic soft_n;
  logic por_n;
  logic mask_req;
  logic nmi_syn;
  logic [7:0] int_syn;
  logic wake;
  logic exc_wake;
  logic soft_eff_low;
  logic any_reset;
  crp_state_t state;
  crp_state_t next_state;
  logic [CRP_CNT_W-1:0] cnt;
  logic [CRP_CNT_W-1:0] next_cnt;
  logic sleep;
  logic next_sleep;
  logic [31:0] next_status;
  logic [31:0] next_debug;

  // ==========================================================
  // helpers
  // counter load that starts a fresh six-cycle reset pulse
  function automatic logic [CRP_CNT_W-1:0] pulse_load();
    return CRP_CNT_W'(CRP_RESET_PULSE_CYCLES - 1);
  endfunction

  // ==========================================================
  // pin synchronisers
  // one synchroniser for every pin keeps the soft reset and the mask request
  // aligned, so a mask that arrives together with the soft reset is honoured
  // resynchronise reset pins
  crp_sync #(.W(12), .INIT(12'h000)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({link.soft_reset_in_n, link.power_on_reset_in_n, link.soft_reset_mask_req,
        link.nmi, link.hw_int}),
    .q(syn)
  );

  // split the synchronised pins; reset pins read low until the pipe fills
  assign soft_n = syn[11];
  assign por_n = syn[10];
  assign mask_req = syn[9];
  assign nmi_syn = syn[8];
  assign int_syn = syn[7:0];

  // ==========================================================
  // reset and wake decode
  // wake sources keep sampling during idle
  assign wake = nmi_syn | (|int_syn);
  // an exception taken while idle ends the idle state too
  assign exc_wake = dbg_req || err_req || exc_req;
  // mask soft reset only in debug mode
  assign soft_eff_low = !soft_n && !(mask_req && debug_reg[CRP_DEBUG_MODE_BIT]);
  // power-on reset wins regardless of soft
  assign any_reset = !por_n || soft_eff_low;

  // ==========================================================
  // sequencer: pulse counts down after the last sampled reset, run executes,
  // idle stands in for the stopped internal clock until a wake source
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sleep = sleep;
    if (any_reset) begin
      next_state = CRP_PULSE;
      next_cnt = pulse_load();
      next_sleep = 1'b0;
    end else begin
      case (state)
        CRP_PULSE: begin
          if (cnt == '0) begin
            next_state = CRP_RUN;
          end else begin
            next_cnt = cnt - CRP_CNT_W'(1);
          end
        end
        CRP_RUN: begin
          if (wait_req && !wake) begin
            next_state = CRP_IDLE;
            next_sleep = 1'b1;
          end
        end
        CRP_IDLE: begin
          if (wake || exc_wake) begin
            next_state = CRP_RUN;
            next_sleep = 1'b0;
          end
        end
        default: begin
          next_state = CRP_PULSE;
          next_cnt = pulse_load();
          next_sleep = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= CRP_PULSE;
      cnt <= pulse_load();
      sleep <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      sleep <= next_sleep;
    end
  end

  // ==========================================================
  // level bits and soft-reset flag
  // requests that arrive while the reset pulse runs are dropped
  always_comb begin
    next_status = status_reg;
    next_debug = debug_reg;
    if (any_reset) begin
      next_status = CRP_STATUS_RESET;
      next_debug = CRP_DEBUG_RESET;
      next_status[CRP_STATUS_SOFT_FLAG_BIT] = por_n;
    end else if (state != CRP_PULSE) begin
      if (dbg_req) begin
        next_debug[CRP_DEBUG_MODE_BIT] = 1'b1;
      end else if (err_req) begin
        next_status[CRP_STATUS_ERR_LVL_BIT] = 1'b1;
      end else if (exc_req) begin
        next_status[CRP_STATUS_EXC_LVL_BIT] = 1'b1;
      end else if (deret_req) begin
        next_debug[CRP_DEBUG_MODE_BIT] = 1'b0;
      end else if (eret_req) begin
        // return clears the error level first, then the exception level
        if (status_reg[CRP_STATUS_ERR_LVL_BIT]) begin
          next_status[CRP_STATUS_ERR_LVL_BIT] = 1'b0;
        end else begin
          next_status[CRP_STATUS_EXC_LVL_BIT] = 1'b0;
        end
      end
      // software clears the soft-reset flag
      if (soft_flag_clear) begin
        next_status[CRP_STATUS_SOFT_FLAG_BIT] = 1'b0;
      end
    end
  end

  // level bits hold while clock enable is low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_reg <= CRP_STATUS_RESET;
      debug_reg <= CRP_DEBUG_RESET;
    end else if (ce) begin
      status_reg <= next_status;
      debug_reg <= next_debug;
    end
  end

  // ==========================================================
  // outputs
  // exception level mirror
  assign link.exception_level_out = status_reg[CRP_STATUS_EXC_LVL_BIT];
  assign link.error_level_out = status_reg[CRP_STATUS_ERR_LVL_BIT];
  assign link.debug_mode_out = debug_reg[CRP_DEBUG_MODE_BIT];
  assign link.sleep_out = sleep;
  // reset pulse in progress
  assign link.core_reset_active = (state == CRP_PULSE);
  assign core_run = (state == CRP_RUN);
endmodule // crp_core

// file: crp_if.sv
/*
  crp_if: pins between the core and the system power and clock logic.
  Assumes both ends share clk; the testbench joins the modports.
*/
`timescale 1ns/100ps
interface crp_if;
  logic soft_reset_in_n;
  logic power_on_reset_in_n;
  logic soft_reset_mask_req;
  logic [7:0] hw_int;
  logic nmi;
  logic exception_level_out;
  logic error_level_out;
  logic debug_mode_out;
  logic sleep_out;
  logic core_reset_active;

  // ==========================================================
  // core end
  modport core (
    input soft_reset_in_n, power_on_reset_in_n, soft_reset_mask_req, hw_int, nmi,
    output exception_level_out, error_level_out, debug_mode_out, sleep_out,
    core_reset_active
  );

  // ==========================================================
  // system power logic end
  modport sys (
    output soft_reset_in_n, power_on_reset_in_n, soft_reset_mask_req, hw_int, nmi,
    input exception_level_out, error_level_out, debug_mode_out, sleep_out,
    core_reset_active
  );
endinterface

// file: crp_pkg.sv
/*
  crp_pkg: constants and types shared by the core reset and power state ends.
  Assumes a single 100 MHz core clock on both ends.
*/
// What this block does
// - both resets active low, any timing
// - reset pulse six cycles, synchronous release
// - power-on low resets regardless of soft
// - soft-only reset sets soft-reset flag
// - probe may mask soft reset in debug
// - never mask soft outside debug, power-on never
// - system asserts a reset at power-on
// - static design, clock may slow or stop
// - exception sets exactly one matching level bit
// - exception-level out follows status bit 1
// - error-level out follows status bit 2
// - debug-mode out follows debug bit 30
// - power logic watches levels, raises wake_req
// - idle stops clock, inputs keep sampled
// - interrupt, NMI or reset ends idle
// - sleep asserted when idle instruction executes
package crp_pkg;

  // ==========================================================
  // timing
  localparam int CRP_CLK_PERIOD_NS = 10;
  localparam int CRP_RESET_PULSE_CYCLES = 6;
  localparam int CRP_CNT_W = 3;

  // ==========================================================
  // register field positions
  localparam int CRP_STATUS_EXC_LVL_BIT = 1;
  localparam int CRP_STATUS_ERR_LVL_BIT = 2;
  localparam int CRP_STATUS_SOFT_FLAG_BIT = 20;
  localparam int CRP_DEBUG_MODE_BIT = 30;
  localparam logic [31:0] CRP_STATUS_RESET = 32'h0000_0004;
  localparam logic [31:0] CRP_DEBUG_RESET = 32'h0000_0000;
  // link control after reset: power-on reset pin held low
  localparam logic [31:0] CRP_LINK_RESET = 32'h0000_0002;

  // ==========================================================
  // software port offsets of the controller
  localparam logic [3:0] CRP_OFS_STATUS = 4'h0;
  localparam logic [3:0] CRP_OFS_DEBUG = 4'h1;
  localparam logic [3:0] CRP_OFS_CMD = 4'h2;
  localparam logic [3:0] CRP_OFS_LINK = 4'h3;

  // command bits in the command register
  localparam int CRP_CMD_EXC = 0;
  localparam int CRP_CMD_ERR = 1;
  localparam int CRP_CMD_DBG = 2;
  localparam int CRP_CMD_RET = 3;
  localparam int CRP_CMD_WAIT = 4;
  localparam int CRP_CMD_DERET = 5;

  // exception kinds
  typedef enum logic [1:0] {
    CRP_EXC_NONE,
    CRP_EXC_GENERAL,
    CRP_EXC_ERROR,
    CRP_EXC_DEBUG
  } crp_exc_t;

  // reset sequencer states
  typedef enum logic [1:0] {
    CRP_RUN,
    CRP_PULSE,
    CRP_IDLE
  } crp_state_t;

endpackage

// file: crp_sync.sv
/*
  crp_sync: two flip-flop synchroniser for a bus of levels.
  Assumes inputs are asynchronous to clk; reset value is a parameter.
*/
`timescale 1ns/100ps
module crp_sync
  import crp_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // ==========================================================
  // next values; first stage feeds only the second
  always_comb begin
    next_meta = meta;
    next_q = q;
    if (!rst_n) begin
      next_meta = INIT;
      next_q = INIT;
    end else if (ce) begin
      next_meta = d;
      next_q = meta;
    end
  end

  // registers
  always_ff @(posedge clk) begin
    meta <= next_meta;
    q <= next_q;
  end
endmodule // crp_sync

// file: crp_sys.sv
/*
  crp_sys: system power logic end, driven by software through a small port.
  Assumes core outputs are on the same clk; read data one cycle after strobe.
*/
`timescale 1ns/100ps
module crp_sys
  import crp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  crp_if.sys link,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic wake_req
);
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [31:0] next_rdata;
  logic next_wake;

  // ==========================================================
  // ctrl bits: 0 soft reset low, 1 power-on reset low, 2 mask request,
  // 3 nmi, 15:8 interrupts; power-on reset held after reset
  always_comb begin
    next_ctrl = ctrl;
    next_rdata = 32'h0000_0000;
    if (wr && addr == CRP_OFS_LINK) begin
      next_ctrl = wdata & 32'h0000_ff0f;
    end
    if (rd) begin
      case (addr)
        CRP_OFS_LINK: next_rdata = ctrl;
        CRP_OFS_STATUS: next_rdata = {27'h0, link.core_reset_active, link.sleep_out,
                                       link.debug_mode_out, link.error_level_out,
                                       link.exception_level_out};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    // wake while sleeping and any level bit is high
    next_wake = link.sleep_out &&
                (link.exception_level_out || link.error_level_out || link.debug_mode_out);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= CRP_LINK_RESET;
      rdata <= 32'h0000_0000;
      wake_req <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl;
      rdata <= next_rdata;
      wake_req <= next_wake;
    end
  end

  assign link.soft_reset_in_n = !ctrl[0];
  assign link.power_on_reset_in_n = !ctrl[1];
  assign link.soft_reset_mask_req = ctrl[2];
  assign link.nmi = ctrl[3];
  assign link.hw_int = ctrl[15:8];
endmodule // crp_sys

// file: tb.sv
/*
  tb: drives both ends of the reset and power link and judges them.
  Assumes link control bit 0 asserts soft reset, bit 1 power-on reset.
*/
`timescale 1ns/100ps
module tb
  import crp_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] cmd = 7'h00;
  logic [31:0] rdata, status_reg, debug_reg;
  logic core_run;
  logic wake_req;
  logic ce = 1'b1;
  int fail_count = 0;
  int checks = 0;
  crp_if link_if();
  wire [2:0] lvl = {link_if.debug_mode_out, link_if.error_level_out,
    link_if.exception_level_out};

  // ==========================================================
  // both ends facing each other
  crp_core crp_core_inst(.clk(clk), .rst_n(rst_n), .ce(ce), .link(link_if.core),
    .exc_req(cmd[CRP_CMD_EXC]), .err_req(cmd[CRP_CMD_ERR]), .dbg_req(cmd[CRP_CMD_DBG]),
    .eret_req(cmd[CRP_CMD_RET]), .deret_req(cmd[CRP_CMD_DERET]),
    .wait_req(cmd[CRP_CMD_WAIT]), .soft_flag_clear(cmd[6]), .status_reg(status_reg),
    .debug_reg(debug_reg), .core_run(core_run));
  crp_sys crp_sys_inst(.clk(clk), .rst_n(rst_n), .ce(ce), .link(link_if.sys),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wake_req(wake_req));
  crp_checker crp_checker_inst(.clk(clk), .rst_n(rst_n),
    .soft_reset_in_n(link_if.soft_reset_in_n),
    .power_on_reset_in_n(link_if.power_on_reset_in_n),
    .soft_reset_mask_req(link_if.soft_reset_mask_req), .hw_int(link_if.hw_int),
    .nmi(link_if.nmi), .exception_level_out(link_if.exception_level_out),
    .error_level_out(link_if.error_level_out), .debug_mode_out(link_if.debug_mode_out),
    .sleep_out(link_if.sleep_out), .core_reset_active(link_if.core_reset_active));

  // free-running core clock
  always #5 clk = ~clk;

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // one-cycle command pulse, then let it settle
  task automatic op(input int b);
    @(posedge clk);
    cmd <= 7'h01 << b;
    @(posedge clk);
    cmd <= 7'h00;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic wait_run();
    for (int i = 0; i < 40 && core_run !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(core_run, 32'h1);
    chk(link_if.core_reset_active, 32'h0);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_boot();
    logic [31:0] d;
    reg_wr(CRP_OFS_LINK, 32'h0);
    chk(link_if.power_on_reset_in_n, 32'h1);
    wait_run();
    reg_rd(4'h7, d);
    chk(d, 32'h0);
    reg_rd(CRP_OFS_STATUS, d);
    chk(d, 32'h2);
  endtask

  task automatic t_levels();
    int seq [7] = '{CRP_CMD_RET, CRP_CMD_EXC, CRP_CMD_DBG, CRP_CMD_DERET,
      CRP_CMD_ERR, CRP_CMD_RET, CRP_CMD_RET};
    logic [2:0] exp [7] = '{3'h0, 3'h1, 3'h5, 3'h1, 3'h3, 3'h1, 3'h0};
    for (int i = 0; i < 7; i++) begin
      op(seq[i]);
      chk(lvl, exp[i]);
      chk({debug_reg[30], status_reg[2:1]}, exp[i]);
    end
  endtask

  task automatic t_soft();
    reg_wr(CRP_OFS_LINK, 32'h1);
    chk(link_if.soft_reset_in_n, 32'h0);
    repeat (6) @(posedge clk);
    #1;
    chk(link_if.core_reset_active, 32'h1);
    reg_wr(CRP_OFS_LINK, 32'h0);
    wait_run();
    chk(status_reg[CRP_STATUS_SOFT_FLAG_BIT], 32'h1);
    op(6);
    chk(status_reg[CRP_STATUS_SOFT_FLAG_BIT], 32'h0);
  endtask

  task automatic t_sleep();
    op(CRP_CMD_WAIT);
    chk(link_if.sleep_out, 32'h1);
    reg_wr(CRP_OFS_LINK, 32'h2);
    repeat (6) @(posedge clk);
    #1;
    chk(link_if.sleep_out, 32'h0);
    chk(link_if.core_reset_active, 32'h1);
    reg_wr(CRP_OFS_LINK, 32'h0);
    wait_run();
    chk(status_reg[CRP_STATUS_SOFT_FLAG_BIT], 32'h0);
    chk(lvl, 32'h2);
    // sleep again with the error level up, then wake by an interrupt
    op(CRP_CMD_WAIT);
    chk(link_if.sleep_out, 32'h1);
    chk(wake_req, 32'h1);
    reg_wr(CRP_OFS_LINK, 32'h100);
    repeat (3) @(posedge clk);
    #1;
    chk(link_if.sleep_out, 32'h0);
    chk(core_run, 32'h1);
    // release the interrupt, let it drain through the synchroniser, wake by nmi
    reg_wr(CRP_OFS_LINK, 32'h0);
    repeat (2) @(posedge clk);
    op(CRP_CMD_WAIT);
    chk(link_if.sleep_out, 32'h1);
    reg_wr(CRP_OFS_LINK, 32'h8);
    repeat (3) @(posedge clk);
    #1;
    chk(link_if.sleep_out, 32'h0);
    reg_wr(CRP_OFS_LINK, 32'h0);
  endtask

  // soft reset masked in debug mode, taken once the mask request drops
  task automatic t_mask();
    logic [31:0] d;
    op(CRP_CMD_DBG);
    chk(lvl, 32'h6);
    reg_wr(CRP_OFS_LINK, 32'h5);
    reg_rd(CRP_OFS_LINK, d);
    chk(d, 32'h5);
    repeat (4) @(posedge clk);
    #1;
    chk(link_if.core_reset_active, 32'h0);
    chk(lvl, 32'h6);
    reg_wr(CRP_OFS_LINK, 32'h1);
    repeat (6) @(posedge clk);
    #1;
    chk(link_if.core_reset_active, 32'h1);
    reg_wr(CRP_OFS_LINK, 32'h0);
    wait_run();
    chk(lvl, 32'h2);
  endtask

  // clock enable low freezes the core; work resumes afterwards
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    op(CRP_CMD_EXC);
    chk(lvl, 32'h0);
    chk(core_run, 32'h1);
    @(posedge clk);
    ce <= 1'b1;
    op(CRP_CMD_EXC);
    chk(lvl, 32'h1);
    op(CRP_CMD_RET);
    chk(lvl, 32'h0);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    chk(link_if.sleep_out, 32'h0);
    chk(status_reg, CRP_STATUS_RESET);
    chk(debug_reg, CRP_DEBUG_RESET);
    @(posedge clk);
    rst_n <= 1'b1;
    t_boot();
    t_levels();
    t_freeze();
    t_soft();
    t_sleep();
    t_mask();
    close_out();
  end

  // watchdog against a hang
  initial begin
    #100000;
    fail_count++;
    close_out();
  end
endmodule // tb
